// [blink_timer.v]
// One retriggerable blink timer: pulse while counting down.
// Assumes a start pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hub_indicator_defines.vh"
module blink_timer #(
  parameter [`BLINK_COUNT_W-1:0] LENGTH = `BLINK_CYCLES
) (
  // Clocking
  input wire clock,
  input wire rst,
  input wire clockEnable,
  // Control
  input wire start,
  output wire active
);
  reg [`BLINK_COUNT_W-1:0] count;
  assign active = (count != {`BLINK_COUNT_W{1'b0}});
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= {`BLINK_COUNT_W{1'b0}};
    end else if (clockEnable) begin
      // Retrigger restarts the full length so back-to-back traffic stays visible
      if (start) begin
        count <= LENGTH;
      end else if (active) begin
        count <= count - {{(`BLINK_COUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // blink_timer
`default_nettype wire

// [hub_indicator_defines.vh]
// Constants for the hub link indicator and attach logic.
// Assumes a 250 MHz hub clock; included by the design files.
`ifndef HUB_INDICATOR_DEFINES_VH
`define HUB_INDICATOR_DEFINES_VH
`define CLOCK_PERIOD_PS 4000
`define BLINK_TIME_MS 128
// 128 ms at 4 ns per cycle is 32,000,000 cycles, sized to the counter
`define BLINK_CYCLES 26'h1E84800
`define BLINK_COUNT_W 26
// 250 MHz / 12 MHz is not whole: fractional accumulator, 24/250 per cycle
`define MCU_CLOCK_MHZ 12
`define HUB_CLOCK_MHZ 250
`define ACC_W 9
// Accumulator adds two edges per MCU cycle and wraps at the hub rate
`define ACC_STEP 9'h018
`define ACC_WRAP 9'h0FA
`define DOWN_PORTS 2
`define Y_GPIO_WIDTH 18
`endif

// [hub_link_indicator_connect.v]
// Indicator, shared-pin selection, attach pull-up and MCU clock for the hub.
// Assumes hub-core events are one-cycle pulses on the hub clock; pins pass synchronisers.
//
// How it works
// (RULE1) Select bit 0: shared upstream pin is open-drain upstream activity indicator.
// (RULE2) Select bit 1: same pin becomes open-drain EEPROM chip select.
// (RULE3) Overcurrent enable 0: downstream pin is indicator; 1: overcurrent sense input.
// (RULE4) Pull-up enable picks pull-up or weak pull-down on Y-group pins.
// (RULE5) During enumeration indicators blink briefly, never steady.
// (RULE6) After configuration indicators stay on except traffic blinks. Here only upstream stays on; downstream lights only during an ack blink.
// (RULE7) Packet to hub turns upstream indicator off about 128 ms.
// (RULE8) Downstream indicator blinks on each acknowledge from its port.
// (RULE9) In suspend every indicator is off.
// (RULE10) D+ pull-up is disconnected after reset.
// (RULE11) Soft attach bit connects or disconnects the D+ pull-up.
// (RULE12) Connect bit switches the pull-up supply rail, default off.
// (RULE13) MCU reaches hub only via command and data registers in external memory.
// (RULE14) MCU clock is 12 MHz, derived from the hub clock.
// (RULE15) MCU clock appears on a dedicated output pin.
// (RULE16) Every downstream port status change is flagged for the status endpoint.
// (RULE17) Indicator on means output pulls low; selection changes act next clock.
// (RULE18) Enumeration and acknowledge blink length is a fixed 128 ms parameter.
`timescale 1ns/1ps
`default_nettype none
`include "hub_indicator_defines.vh"
module hub_link_indicator_connect #(
  // Blink length in hub clock cycles; only simulation shortens it
  parameter [`BLINK_COUNT_W-1:0] BLINK_LENGTH = `BLINK_CYCLES // RULE18
) (
  // Clocking
  input wire clock,
  input wire rst,
  input wire clockEnable,
  // Control bits from the hub control register
  input wire indicatorChipselectChoice,
  input wire overcurrentSenseEnable,
  input wire ioPullupEnable,
  input wire softAttachBit,
  input wire deviceConnectBit,
  input wire eepromSelect,
  // Hub core events and states
  input wire enumerating,
  input wire configured,
  input wire suspended,
  input wire hubPacket,
  input wire enumActivity,
  input wire [`DOWN_PORTS-1:0] downstreamAck,
  input wire [`DOWN_PORTS-1:0] portStatusChange,
  input wire [`DOWN_PORTS-1:0] statusChangeTaken,
  // Pins
  input wire [`DOWN_PORTS-1:0] downstreamSensePin,
  output reg upstreamIndicatorOrEepromSelectOe,
  output reg [`DOWN_PORTS-1:0] downstreamSenseOrIndicatorOe,
  output reg [`DOWN_PORTS-1:0] overcurrentDetected,
  output reg yGroupPullupOn,
  output reg yGroupPulldownOn,
  output reg dplusPullupAttach,
  output reg pullupSupplyRailOn,
  output reg mcuClockOut,
  output reg [`DOWN_PORTS-1:0] portChangeFlag
);
  // Output enable low means the pin is driven low (LED lit / select asserted)
  wire upBlink;
  wire [`DOWN_PORTS-1:0] downBlink;
  wire enumBlink;
  reg [`DOWN_PORTS-1:0] senseMeta;
  reg [`DOWN_PORTS-1:0] senseSync;
  reg [`ACC_W-1:0] phaseAcc;
  reg [`ACC_W-1:0] next_phaseAcc;
  reg [`ACC_W-1:0] accSum;
  reg accWrap;
  reg upLit;
  reg [`DOWN_PORTS-1:0] downLit;
  reg next_upOe;
  reg [`DOWN_PORTS-1:0] next_downOe;
  reg [`DOWN_PORTS-1:0] next_overcurrent;
  reg [`DOWN_PORTS-1:0] next_portChangeFlag;

  // One retriggerable timer per indicator event
  blink_timer #(.LENGTH(BLINK_LENGTH)) upTimer (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .start(hubPacket), // RULE7
    .active(upBlink)
  );

  // Enumeration blinks share one timer, so all indicators blink together
  blink_timer #(.LENGTH(BLINK_LENGTH)) enumTimer (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .start(enumActivity), // RULE18
    .active(enumBlink)
  );

  // One acknowledge timer per downstream port
  genvar g;
  generate
    for (g = 0; g < `DOWN_PORTS; g = g + 1) begin : downTimers
      blink_timer #(.LENGTH(BLINK_LENGTH)) ackTimer (
        .clock(clock),
        .rst(rst),
        .clockEnable(clockEnable),
        .start(downstreamAck[g]), // RULE8
        .active(downBlink[g])
      );
    end
  endgenerate

  // Indicator levels before pin muxing
  always @* begin
    if (suspended) begin
      upLit = 1'b0; // RULE9
      downLit = {`DOWN_PORTS{1'b0}}; // RULE9
    end else if (configured) begin
      upLit = ~upBlink; // RULE6 RULE7
      downLit = downBlink; // RULE8
    end else if (enumerating) begin
      upLit = enumBlink; // RULE5
      downLit = {`DOWN_PORTS{enumBlink}}; // RULE5
    end else begin
      upLit = 1'b0;
      downLit = {`DOWN_PORTS{1'b0}};
    end
  end

  // Fractional divider: 24 of every 250 edges toggle, 12 MHz on average
  // A whole divider cannot reach 12 MHz from 250 MHz; 4 ns of jitter is the price
  always @* begin
    accSum = phaseAcc + `ACC_STEP;
    accWrap = (accSum >= `ACC_WRAP);
    if (accWrap) begin
      next_phaseAcc = accSum - `ACC_WRAP;
    end else begin
      next_phaseAcc = accSum;
    end
  end

  // Shared pin functions; a selection change acts at the next enabled edge
  always @* begin
    if (indicatorChipselectChoice) begin
      next_upOe = ~eepromSelect; // RULE2 RULE17
    end else begin
      next_upOe = ~upLit; // RULE1 RULE17
    end
    if (overcurrentSenseEnable) begin
      next_downOe = {`DOWN_PORTS{1'b1}}; // RULE3
      next_overcurrent = senseSync; // RULE3
    end else begin
      next_downOe = ~downLit; // RULE3 RULE17
      next_overcurrent = {`DOWN_PORTS{1'b0}};
    end
  end

  // Set wins over a clear in the same cycle, so no change is ever lost
  always @* begin
    next_portChangeFlag = (portChangeFlag & ~statusChangeTaken) | portStatusChange; // RULE16
  end

  // Sense pins are asynchronous; only senseSync reads senseMeta
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      senseMeta <= {`DOWN_PORTS{1'b0}};
      senseSync <= {`DOWN_PORTS{1'b0}};
    end else if (clockEnable) begin
      senseMeta <= downstreamSensePin;
      senseSync <= senseMeta;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phaseAcc <= {`ACC_W{1'b0}};
      mcuClockOut <= 1'b0;
    end else if (clockEnable) begin
      phaseAcc <= next_phaseAcc;
      if (accWrap) begin
        mcuClockOut <= ~mcuClockOut; // RULE14 RULE15
      end
    end
  end

  // Pin enables and the sense result come straight from flip-flops
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      upstreamIndicatorOrEepromSelectOe <= 1'b1;
      downstreamSenseOrIndicatorOe <= {`DOWN_PORTS{1'b1}};
      overcurrentDetected <= {`DOWN_PORTS{1'b0}};
    end else if (clockEnable) begin
      upstreamIndicatorOrEepromSelectOe <= next_upOe;
      downstreamSenseOrIndicatorOe <= next_downOe;
      overcurrentDetected <= next_overcurrent;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      portChangeFlag <= {`DOWN_PORTS{1'b0}};
    end else if (clockEnable) begin
      portChangeFlag <= next_portChangeFlag; // RULE16
    end
  end

  // Attach stays off through reset so the host sees nothing until firmware is ready
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      yGroupPullupOn <= 1'b0;
      yGroupPulldownOn <= 1'b1;
      dplusPullupAttach <= 1'b0; // RULE10
      pullupSupplyRailOn <= 1'b0; // RULE12
    end else if (clockEnable) begin
      yGroupPullupOn <= ioPullupEnable; // RULE4
      yGroupPulldownOn <= ~ioPullupEnable; // RULE4
      dplusPullupAttach <= softAttachBit; // RULE11
      pullupSupplyRailOn <= deviceConnectBit; // RULE12
    end
  end
  // RULE13 is the MCU's register path, outside this block
  // Its command and data bits arrive here as plain ports
endmodule // hub_link_indicator_connect
`default_nettype wire

// [hub_link_indicator_connect_bench.sv]
// Self-checking bench for the hub indicator and attach block.
// Assumes design, checker and partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module hub_link_indicator_connect_bench;
  logic clock, rst, clockEnable, indicatorChipselectChoice, overcurrentSenseEnable;
  logic ioPullupEnable, softAttachBit, deviceConnectBit, eepromSelect, enumerating;
  logic configured, suspended, hubPacket, enumActivity, upstreamIndicatorOrEepromSelectOe;
  logic yGroupPullupOn, yGroupPulldownOn, dplusPullupAttach, pullupSupplyRailOn, mcuClockOut;
  logic [1:0] downstreamAck, portStatusChange, statusChangeTaken, downstreamSensePin;
  logic [1:0] downstreamSenseOrIndicatorOe, overcurrentDetected, portChangeFlag, fault, dnLed;
  logic upLed;
  logic [2:0] r;
  logic [3:0] ctlSeen, prevCtl;
  logic prevClk;
  int n_fail, compares, toggles;
  integer seed;
  // Short blinks keep the whole run well inside the cycle budget
  localparam logic [25:0] BLINK = 26'h0000010;
  assign ctlSeen = {dplusPullupAttach, pullupSupplyRailOn, yGroupPullupOn, yGroupPulldownOn};
  hub_link_indicator_connect #(.BLINK_LENGTH(BLINK)) i_dut (
    .clock(clock), .rst(rst), .clockEnable(clockEnable),
    .indicatorChipselectChoice(indicatorChipselectChoice),
    .overcurrentSenseEnable(overcurrentSenseEnable), .ioPullupEnable(ioPullupEnable),
    .softAttachBit(softAttachBit), .deviceConnectBit(deviceConnectBit),
    .eepromSelect(eepromSelect), .enumerating(enumerating), .configured(configured),
    .suspended(suspended), .hubPacket(hubPacket), .enumActivity(enumActivity),
    .downstreamAck(downstreamAck), .portStatusChange(portStatusChange),
    .statusChangeTaken(statusChangeTaken), .downstreamSensePin(downstreamSensePin),
    .upstreamIndicatorOrEepromSelectOe(upstreamIndicatorOrEepromSelectOe),
    .downstreamSenseOrIndicatorOe(downstreamSenseOrIndicatorOe),
    .overcurrentDetected(overcurrentDetected), .yGroupPullupOn(yGroupPullupOn),
    .yGroupPulldownOn(yGroupPulldownOn), .dplusPullupAttach(dplusPullupAttach),
    .pullupSupplyRailOn(pullupSupplyRailOn), .mcuClockOut(mcuClockOut),
    .portChangeFlag(portChangeFlag));
  led_host_partner i_far (.upOe(upstreamIndicatorOrEepromSelectOe),
    .dnOe(downstreamSenseOrIndicatorOe), .fault(fault), .upLed(upLed), .dnLed(dnLed),
    .sensePin(downstreamSensePin));
  // Attach, rail, pull-up, pull-down from the control bits
  function automatic logic [3:0] expCtl(input logic [2:0] v);
    return {v, !v[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic complete_run;
    $display("Checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #2 clock = !clock;
  end
  // Whole run is about 600 cycles; the limit allows about eight times that
  initial begin
    #20000;
    n_fail++;
    complete_run;
  end
  initial begin
    seed = 32'h002BD40C;
    {indicatorChipselectChoice, overcurrentSenseEnable, ioPullupEnable, softAttachBit} = 4'h0;
    {deviceConnectBit, eepromSelect, enumerating, configured, suspended} = 5'h00;
    {hubPacket, enumActivity, downstreamAck, portStatusChange, statusChangeTaken} = 8'h00;
    {rst, clockEnable, fault} = 4'h8;
    tick(4);
    chk("reset", ctlSeen, 4'h1);
    rst = 0;
    indicatorChipselectChoice = 1;
    for (int i = 0; i < 300; i++) begin
      r = 3'($random(seed));
      prevCtl = ctlSeen;
      {softAttachBit, deviceConnectBit, ioPullupEnable} = r;
      {clockEnable, eepromSelect} = {r[1] | r[2], r[0]};
      tick(1);
      if (clockEnable) begin
        chk("ctl", ctlSeen, expCtl(r));
      end else begin
        chk("hold", ctlSeen, prevCtl);
      end
      if (clockEnable) chk("select", upstreamIndicatorOrEepromSelectOe, !eepromSelect);
    end
    {indicatorChipselectChoice, clockEnable, configured} = 3'h3;
    tick(3);
    chk("steady", {upLed, dnLed}, 4'h4);
    {hubPacket, downstreamAck} = 3'h6;
    tick(1);
    {hubPacket, downstreamAck} = 3'h0;
    tick(2);
    chk("traffic", {upLed, dnLed}, 4'h2);
    suspended = 1;
    tick(3);
    chk("suspend", {upLed, dnLed}, 4'h0);
    {suspended, configured, enumerating, enumActivity} = 4'h3;
    tick(1);
    enumActivity = 0;
    tick(2);
    chk("enum", upLed, 4'h1);
    tick(BLINK);
    chk("enum end", upLed, 4'h0);
    {enumerating, configured, hubPacket, downstreamAck} = 5'h0D;
    tick(1);
    {hubPacket, downstreamAck} = 3'h0;
    tick(BLINK);
    chk("blink held", {upLed, dnLed}, 4'h1);
    tick(1);
    chk("restore", {upLed, dnLed}, 4'h4);
    {overcurrentSenseEnable, fault, portStatusChange} = 5'h15;
    tick(1);
    // Port 1 is set and cleared in one cycle: the set must win
    {portStatusChange, statusChangeTaken} = 4'hB;
    tick(1);
    chk("flag", portChangeFlag, 4'h2);
    {portStatusChange, statusChangeTaken} = 4'h0;
    tick(2);
    chk("sense", {overcurrentDetected, downstreamSenseOrIndicatorOe}, 4'h7);
    // 12 MHz gives 24 edges per microsecond, which is 250 hub cycles
    toggles = 0;
    prevClk = mcuClockOut;
    repeat (250) begin
      tick(1);
      if (mcuClockOut !== prevClk) toggles++;
      prevClk = mcuClockOut;
    end
    chk("mcu toggles", 8'(toggles), 8'h18);
    {softAttachBit, deviceConnectBit} = 2'h3;
    tick(1);
    rst = 1;
    tick(1);
    chk("reset again", {dplusPullupAttach, pullupSupplyRailOn}, 4'h0);
    rst = 0;
    tick(1);
    chk("attach again", {dplusPullupAttach, pullupSupplyRailOn}, 4'h3);
    complete_run;
  end
endmodule // hub_link_indicator_connect_bench
`default_nettype wire

// [hub_link_monitor.sv]
// Checker for the hub indicator and attach outputs.
// Assumes the top module's ports on one clock.
`timescale 1ns/1ps
`default_nettype none
module hub_link_monitor (
  // Clocking
  input wire logic clock, rst, clockEnable,
  // Controls and events
  input wire logic indicatorChipselectChoice, overcurrentSenseEnable, ioPullupEnable,
  input wire logic softAttachBit, deviceConnectBit, eepromSelect, configured, suspended,
  input wire logic hubPacket,
  input wire logic [1:0] portStatusChange,
  // Outputs
  input wire logic upstreamIndicatorOrEepromSelectOe, yGroupPullupOn, yGroupPulldownOn,
  input wire logic dplusPullupAttach, pullupSupplyRailOn,
  input wire logic [1:0] downstreamSenseOrIndicatorOe, overcurrentDetected, portChangeFlag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_attach_follow: assert property (
    clockEnable |=> dplusPullupAttach == $past(softAttachBit)) else $error("attach wrong");
  a_rail_follow: assert property (
    clockEnable |=> pullupSupplyRailOn == $past(deviceConnectBit)) else $error("rail wrong");
  a_pull_pair: assert property (
    clockEnable |=> yGroupPullupOn == $past(ioPullupEnable) && yGroupPulldownOn != yGroupPullupOn)
    else $error("pull wrong");
  a_chip_select: assert property (
    clockEnable && indicatorChipselectChoice
    |=> upstreamIndicatorOrEepromSelectOe == !$past(eepromSelect)) else $error("select wrong");
  a_suspend_dark: assert property (
    (clockEnable && suspended && !indicatorChipselectChoice)[*3]
    |-> upstreamIndicatorOrEepromSelectOe) else $error("lit in suspend");
  a_sense_release: assert property (
    (clockEnable && overcurrentSenseEnable)[*3] |-> &downstreamSenseOrIndicatorOe)
    else $error("sense pin driven");
  a_oc_masked: assert property (
    (clockEnable && !overcurrentSenseEnable)[*3] |-> overcurrentDetected == 2'h0)
    else $error("overcurrent while indicator");
  a_flag_set: assert property (
    clockEnable && portStatusChange[0] |=> portChangeFlag[0]) else $error("flag missed");
  a_hub_blink: assert property (
    hubPacket && configured && clockEnable && !suspended && !indicatorChipselectChoice
    ##1 clockEnable && configured && !suspended && !indicatorChipselectChoice
    |=> upstreamIndicatorOrEepromSelectOe) else $error("no off blink");
  cover property (hubPacket && configured);
  cover property (suspended && configured);
  cover property (overcurrentSenseEnable && overcurrentDetected[0]);
endmodule // hub_link_monitor
bind hub_link_indicator_connect hub_link_monitor i_mon (.*);
`default_nettype wire

// [led_host_partner.sv]
// LEDs, overcurrent switch and host seen at the pins.
// Assumes open-drain outputs that drive low while enable is low.
`timescale 1ns/1ps
`default_nettype none
module led_host_partner (
  input wire logic upOe,
  input wire logic [1:0] dnOe, fault,
  output logic upLed,
  output logic [1:0] dnLed, sensePin
);
  // Pull-up holds a released pin high, so an LED lights only when driven low
  assign upLed = !upOe;
  assign dnLed = ~dnOe;
  // Switch reports a fault as a high level, no glitch filtering here
  assign sensePin = fault;
endmodule // led_host_partner
`default_nettype wire
